// >>> core/kbc_pkg.sv
// constants, field positions and carrier types for the keyboard mailbox block
// assumes one core clock of 20 MHz and a synchronous active-low reset
// Summary of operation
// - host data write loads input, command flag 0
// - host command write loads input, command flag 1
// - data read returns output; flag mode clears irq
// - status read has no side effect
// - core output write sets output-full, keyboard irq
// - command flag copies host address bit two
// - flag mode: keyboard irq is output-full gated
// - else keyboard irq follows its port bit
// - flag mode: mouse irq is gated by input-full clear
// - else mouse irq follows its port bit
// - gate a20 output follows its port bit
// - quasi pin: one drives high briefly, then releases
// - open-drain pin: one releases, zero drives low
// - controller-mode pins never inputs nor inverted
// - keyboard pins inverted open-drain, read back
// - mouse pins inverted open-drain, read back
// - halt stops alu; timer runs; host write wakes
// - wake calls routine if input irq enabled
// - stop turns oscillator off; same wake-up
// - only input-full and timer overflow interrupt core
// - two kilobyte program rom, 256 byte ram
// - core input read clears input-full and irq
// - status resets zero; core writes user bits
package kbc_pkg;
  localparam logic [7:0] KBC_DATA_ADDR   = 8'h60;
  localparam logic [7:0] KBC_CMD_ADDR    = 8'h64;
  localparam int         KBC_ST_OBF      = 0;
  localparam int         KBC_ST_IBF      = 1;
  localparam int         KBC_ST_CD       = 3;
  localparam logic [7:0] KBC_ST_UD_MASK  = 8'hF4;
  localparam logic [7:0] KBC_ST_RST      = 8'h00;
  localparam int         KBC_P2_A20      = 1;
  localparam int         KBC_P2_MOUSE_DATA_PIN     = 2;
  localparam int         KBC_P2_MCLK     = 3;
  localparam int         KBC_P2_KEYBOARD_IRQ_OUT     = 4;
  localparam int         KBC_P2_MOUSE_IRQ_OUT     = 5;
  localparam int         KBC_P2_KB_CLOCK_PIN     = 6;
  localparam int         KBC_P2_KB_DATA_PIN     = 7;
  localparam logic [7:0] KBC_P2_RST      = 8'hCC;
  localparam logic [7:0] KBC_P1_RST      = 8'hFF;
  localparam int         KBC_P1_KB_DATA_PIN_IN  = 0;
  localparam int         KBC_P1_MOUSE_DATA_PIN_IN  = 1;
  localparam int         KBC_P1_QA       = 7;
  localparam int         KBC_P1_QB       = 6;
  localparam int         KBC_P1_QC       = 2;
  localparam int         KBC_PIN_KB_CLOCK_PIN    = 0;
  localparam int         KBC_PIN_KB_DATA_PIN    = 1;
  localparam int         KBC_PIN_MCLK    = 2;
  localparam int         KBC_PIN_MOUSE_DATA_PIN    = 3;
  localparam int         KBC_PIN_Q0      = 4;
  localparam int         KBC_PIN_N       = 7;
  localparam int         KBC_QPIN_N      = 3;
  localparam int         KBC_CLK_NS      = 50;
  localparam int         KBC_QPULSE_NS   = 500;
  localparam int         KBC_QPULSE_CYC  = KBC_QPULSE_NS / KBC_CLK_NS;
  localparam int         KBC_QCNT_W      = 4;
  localparam int         KBC_RAM_DEPTH   = 256;
  localparam int         KBC_ROM_DEPTH   = 2048;
  localparam logic [7:0] KBC_ROM_FILL    = 8'h00;
  localparam logic [7:0] KBC_TMR_MAX     = 8'hFF;
  localparam logic [7:0] KBC_TMR_STEP    = 8'h01;

  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       a2;
    logic [7:0] d;
  } kbc_hbus_t;

  typedef enum logic [2:0] {
    KBC_PS_RUN  = 3'b001,
    KBC_PS_HALT = 3'b010,
    KBC_PS_STOP = 3'b100
  } kbc_pwr_t;
endpackage

// >>> core/kbc_qpin.sv
// one controller-mode port pin: quasi-bidirectional or open-drain drive
// assumes an external pull-up and a port bit from the same clock domain
module kbc_qpin (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // port bit and mode
  input  wire logic i_bit,
  input  wire logic i_od,
  // pin drive
  output logic      o_out,
  output logic      o_oe
);
  import kbc_pkg::*;
  localparam logic [KBC_QCNT_W-1:0] QC_LOAD = KBC_QCNT_W'(KBC_QPULSE_CYC - 1);
  logic                  prev_r;
  logic [KBC_QCNT_W-1:0] cnt_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      prev_r <= 1'b1;
      cnt_r  <= '0;
      o_out  <= 1'b0;
      o_oe   <= 1'b0;
    end else begin
      prev_r <= i_bit;
      if (!i_bit) begin
        o_out <= 1'b0;
        o_oe  <= 1'b1;
        cnt_r <= '0;
      end else if (i_od) begin
        o_out <= 1'b0;
        o_oe  <= 1'b0;
        cnt_r <= '0;
      end else if (!prev_r) begin
        o_out <= 1'b1;
        o_oe  <= 1'b1;
        cnt_r <= QC_LOAD;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        o_out <= 1'b0;
        o_oe  <= 1'b0;
      end
    end
  end
endmodule // kbc_qpin

// >>> core/kbc_host_if.sv
// host mailbox, port pins, power states, timer and memories of the keyboard controller
// assumes host strobes arrive asynchronously; core-side ports are on i_core_clk
module kbc_host_if (
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  // host port
  input  wire kbc_pkg::kbc_hbus_t        i_host,
  output logic [7:0]                     o_host_data,
  output logic                           o_host_data_oe,
  // host-side outputs
  output logic                           o_kb_irq,
  output logic                           o_mouse_irq,
  output logic                           o_gate_a20,
  // keyboard, mouse and quasi pins
  input  wire logic [kbc_pkg::KBC_PIN_N-1:0] i_pin_in,
  output logic [kbc_pkg::KBC_PIN_N-1:0]  o_pin_out,
  output logic [kbc_pkg::KBC_PIN_N-1:0]  o_pin_oe,
  // core mailbox
  input  wire logic                      i_core_en_flags,
  input  wire logic                      i_core_obuf_wr,
  input  wire logic [7:0]                i_core_obuf_data,
  input  wire logic                      i_core_obf_clr,
  input  wire logic                      i_core_ibuf_rd,
  output logic [7:0]                     o_core_ibuf_data,
  input  wire logic                      i_core_status_wr,
  input  wire logic [7:0]                i_core_status_ud,
  output logic [7:0]                     o_core_status,
  // core ports
  input  wire logic                      i_core_p1_wr,
  input  wire logic [7:0]                i_core_p1_data,
  input  wire logic                      i_core_p2_wr,
  input  wire logic [7:0]                i_core_p2_data,
  input  wire logic                      i_core_od_mode,
  output logic [7:0]                     o_core_p1_in,
  output logic                           o_core_first_test_input,
  output logic                           o_core_second_test_input,
  // core power and interrupts
  input  wire logic                      i_core_halt,
  input  wire logic                      i_core_stop,
  input  wire logic                      i_core_ibf_ie,
  input  wire logic                      i_core_tmr_ie,
  input  wire logic                      i_core_tmr_en,
  input  wire logic                      i_core_tmr_load,
  input  wire logic [7:0]                i_core_tmr_data,
  input  wire logic                      i_core_tmr_ack,
  output logic                           o_core_irq_ibf,
  output logic                           o_core_irq_tmr,
  output logic                           o_core_alu_run,
  output logic                           o_core_osc_off,
  output logic                           o_core_wake_call,
  output logic                           o_core_wake_next,
  // core memories
  input  wire logic                      i_core_ram_we,
  input  wire logic [7:0]                i_core_ram_addr,
  input  wire logic [7:0]                i_core_ram_wdata,
  output logic [7:0]                     o_core_ram_rdata,
  input  wire logic [10:0]               i_core_rom_addr,
  output logic [7:0]                     o_core_rom_data
);
  import kbc_pkg::*;

  localparam int QC = KBC_QPULSE_CYC;

  // filtered level: a change counts once stages two and three agree
  function automatic logic qual(input logic s2, input logic s3, input logic acc);
    return (s2 == s3) ? s3 : acc;
  endfunction

  function automatic int qpos(input int i);
    return (i == 0) ? KBC_P1_QA : ((i == 1) ? KBC_P1_QB : KBC_P1_QC);
  endfunction

  function automatic logic [7:0] rom_byte(input logic [10:0] a);
    return (int'(a) < KBC_ROM_DEPTH) ? KBC_ROM_FILL : KBC_ROM_FILL;
  endfunction

  kbc_hbus_t              hs1_r, hs2_r, hs3_r;
  logic                   rd_acc_r, wr_acc_r;
  logic                   rd_q, wr_q, hrd_ev, hwr_ev;
  logic [KBC_PIN_N-1:0]   ps1_r, ps2_r, ps3_r, pin_acc_r;
  logic [7:0]             obuf_r, ibuf_r, ud_r, p1_r, p2_r, status_w;
  logic                   obf_r, ibf_r, cd_r, flags_r;
  logic [3:0]             ps2_oe_r;
  logic [KBC_QPIN_N-1:0]  q_out, q_oe;
  kbc_pwr_t               pwr_r;
  logic [7:0]             tmr_r;
  logic                   tovf_r, tmr_tick;
  logic [7:0]             ram_r [KBC_RAM_DEPTH];

  // host strobe, address and data synchroniser
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      hs1_r    <= '{rd_n: 1'b1, wr_n: 1'b1, a2: 1'b0, d: 8'h00};
      hs2_r    <= '{rd_n: 1'b1, wr_n: 1'b1, a2: 1'b0, d: 8'h00};
      hs3_r    <= '{rd_n: 1'b1, wr_n: 1'b1, a2: 1'b0, d: 8'h00};
      rd_acc_r <= 1'b1;
      wr_acc_r <= 1'b1;
    end else begin
      hs1_r    <= i_host;
      hs2_r    <= hs1_r;
      hs3_r    <= hs2_r;
      rd_acc_r <= rd_q;
      wr_acc_r <= wr_q;
    end
  end

  always_comb begin
    rd_q   = qual(hs2_r.rd_n, hs3_r.rd_n, rd_acc_r);
    wr_q   = qual(hs2_r.wr_n, hs3_r.wr_n, wr_acc_r);
    hrd_ev = rd_acc_r && !rd_q;
    hwr_ev = wr_acc_r && !wr_q;
  end

  // status image
  always_comb begin
    status_w             = ud_r & KBC_ST_UD_MASK;
    status_w[KBC_ST_CD]  = cd_r;
    status_w[KBC_ST_IBF] = ibf_r;
    status_w[KBC_ST_OBF] = obf_r;
  end

  // input register and command flag
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ibuf_r <= 8'h00;
      cd_r   <= KBC_ST_RST[KBC_ST_CD];
    end else if (hwr_ev) begin
      ibuf_r <= hs3_r.d;
      cd_r   <= hs3_r.a2;
    end
  end

  // input-full flag: host write wins over core read
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ibf_r <= KBC_ST_RST[KBC_ST_IBF];
    end else if (hwr_ev) begin
      ibf_r <= 1'b1;
    end else if (i_core_ibuf_rd) begin
      ibf_r <= 1'b0;
    end
  end

  // output register and output-full flag: core write wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      obuf_r <= 8'h00;
      obf_r  <= KBC_ST_RST[KBC_ST_OBF];
    end else if (i_core_obuf_wr) begin
      obuf_r <= i_core_obuf_data;
      obf_r  <= 1'b1;
    end else if ((hrd_ev && !hs3_r.a2 && flags_r) || i_core_obf_clr) begin
      obf_r  <= 1'b0;
    end
  end

  // user bits of status and flag mode
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ud_r    <= KBC_ST_RST;
      flags_r <= 1'b0;
    end else begin
      if (i_core_status_wr) begin
        ud_r <= i_core_status_ud & KBC_ST_UD_MASK;
      end
      if (i_core_en_flags) begin
        flags_r <= 1'b1;
      end
    end
  end

  // host read data
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_host_data    <= 8'h00;
      o_host_data_oe <= 1'b0;
    end else begin
      o_host_data_oe <= !rd_q;
      if (hrd_ev) begin
        o_host_data <= hs3_r.a2 ? status_w : obuf_r;
      end
    end
  end

  // core ports
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      p1_r <= KBC_P1_RST;
      p2_r <= KBC_P2_RST;
    end else begin
      if (i_core_p1_wr) begin
        p1_r <= i_core_p1_data;
      end
      if (i_core_p2_wr) begin
        p2_r <= i_core_p2_data;
      end
    end
  end

  // host interrupts and gate a20
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_kb_irq    <= 1'b0;
      o_mouse_irq <= 1'b0;
      o_gate_a20  <= 1'b0;
    end else begin
      o_kb_irq    <= p2_r[KBC_P2_KEYBOARD_IRQ_OUT] && (!flags_r || obf_r);
      o_mouse_irq <= p2_r[KBC_P2_MOUSE_IRQ_OUT] && (!flags_r || !ibf_r);
      o_gate_a20  <= p2_r[KBC_P2_A20];
    end
  end

  // keyboard and mouse lines: a port bit of one pulls the line low
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ps2_oe_r <= 4'hF;
    end else begin
      ps2_oe_r[KBC_PIN_KB_CLOCK_PIN] <= p2_r[KBC_P2_KB_CLOCK_PIN];
      ps2_oe_r[KBC_PIN_KB_DATA_PIN] <= p2_r[KBC_P2_KB_DATA_PIN];
      ps2_oe_r[KBC_PIN_MCLK] <= p2_r[KBC_P2_MCLK];
      ps2_oe_r[KBC_PIN_MOUSE_DATA_PIN] <= p2_r[KBC_P2_MOUSE_DATA_PIN];
    end
  end

  // quasi pins, fixed as outputs without inversion
  for (genvar g = 0; g < KBC_QPIN_N; g++) begin : g_qpin
    kbc_qpin u_qpin (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_bit      (p1_r[qpos(g)]),
      .i_od       (i_core_od_mode),
      .o_out      (q_out[g]),
      .o_oe       (q_oe[g])
    );
  end

  assign o_pin_out = {q_out, 4'h0};
  assign o_pin_oe  = {q_oe, ps2_oe_r};

  // pin read-back synchroniser
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ps1_r     <= '0;
      ps2_r     <= '0;
      ps3_r     <= '0;
      pin_acc_r <= '0;
    end else begin
      ps1_r <= i_pin_in;
      ps2_r <= ps1_r;
      ps3_r <= ps2_r;
      for (int i = 0; i < KBC_PIN_N; i++) begin
        pin_acc_r[i] <= qual(ps2_r[i], ps3_r[i], pin_acc_r[i]);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_p1_in <= KBC_P1_RST;
      o_core_first_test_input <= 1'b0;
      o_core_second_test_input <= 1'b0;
    end else begin
      for (int i = 0; i < KBC_QPIN_N; i++) begin
        o_core_p1_in[qpos(i)] <= pin_acc_r[KBC_PIN_Q0 + i];
      end
      o_core_p1_in[KBC_P1_KB_DATA_PIN_IN] <= pin_acc_r[KBC_PIN_KB_DATA_PIN];
      o_core_p1_in[KBC_P1_MOUSE_DATA_PIN_IN] <= pin_acc_r[KBC_PIN_MOUSE_DATA_PIN];
      o_core_p1_in[5:3]            <= p1_r[5:3];
      o_core_first_test_input                 <= pin_acc_r[KBC_PIN_KB_CLOCK_PIN];
      o_core_second_test_input                 <= pin_acc_r[KBC_PIN_MCLK];
    end
  end

  // mailbox view for the core
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_ibuf_data <= 8'h00;
      o_core_status    <= KBC_ST_RST;
    end else begin
      o_core_ibuf_data <= ibuf_r;
      o_core_status    <= status_w;
    end
  end

  // power states
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pwr_r            <= KBC_PS_RUN;
      o_core_wake_call <= 1'b0;
      o_core_wake_next <= 1'b0;
    end else begin
      o_core_wake_call <= 1'b0;
      o_core_wake_next <= 1'b0;
      case (pwr_r)
        KBC_PS_RUN: begin
          if (i_core_stop) begin
            pwr_r <= KBC_PS_STOP;
          end else if (i_core_halt) begin
            pwr_r <= KBC_PS_HALT;
          end
        end
        KBC_PS_HALT, KBC_PS_STOP: begin
          if (hwr_ev) begin
            pwr_r            <= KBC_PS_RUN;
            o_core_wake_call <= i_core_ibf_ie;
            o_core_wake_next <= !i_core_ibf_ie;
          end
        end
        default: pwr_r <= KBC_PS_RUN;
      endcase
    end
  end

  assign o_core_alu_run = pwr_r[0];
  assign o_core_osc_off = pwr_r[2];

  // timer keeps counting in halt, stops with the oscillator
  assign tmr_tick = i_core_tmr_en && !pwr_r[2] && !i_core_tmr_load;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tmr_r  <= 8'h00;
      tovf_r <= 1'b0;
    end else begin
      if (i_core_tmr_load) begin
        tmr_r <= i_core_tmr_data;
      end else if (tmr_tick) begin
        tmr_r <= tmr_r + KBC_TMR_STEP;
      end
      if (tmr_tick && tmr_r == KBC_TMR_MAX) begin
        tovf_r <= 1'b1;
      end else if (i_core_tmr_ack) begin
        tovf_r <= 1'b0;
      end
    end
  end

  // the two core interrupt sources
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_irq_ibf <= 1'b0;
      o_core_irq_tmr <= 1'b0;
    end else begin
      o_core_irq_ibf <= ibf_r && i_core_ibf_ie;
      o_core_irq_tmr <= tovf_r && i_core_tmr_ie;
    end
  end

  // data ram and program rom
  always_ff @(posedge i_core_clk) begin
    if (i_core_ram_we) begin
      ram_r[i_core_ram_addr] <= i_core_ram_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_ram_rdata <= 8'h00;
      o_core_rom_data  <= KBC_ROM_FILL;
    end else begin
      o_core_ram_rdata <= ram_r[i_core_ram_addr];
      o_core_rom_data  <= rom_byte(i_core_rom_addr);
    end
  end

  // checks
  logic [KBC_QCNT_W:0] qhi_cnt_r;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !(q_oe[0] && q_out[0])) begin
      qhi_cnt_r <= '0;
    end else begin
      qhi_cnt_r <= qhi_cnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_host_wr;
    hwr_ev ##1 1'b1;
  endsequence
  sequence s_obf_read;
    hrd_ev && !hs3_r.a2 && flags_r && !i_core_obuf_wr;
  endsequence

  a_wr_sets_ibf: assert property (s_host_wr |-> ibf_r && ibuf_r == $past(hs3_r.d))
    else $error("host write did not fill input register");
  a_cd_follows_a2: assert property (hwr_ev |=> cd_r == $past(hs3_r.a2))
    else $error("command flag does not match address bit");
  a_obf_on_write: assert property (i_core_obuf_wr |=> obf_r ##1 o_core_status[0])
    else $error("output-full not set after core write");
  a_read_clears_obf: assert property (s_obf_read |=> !obf_r ##1 !o_kb_irq)
    else $error("flag-mode data read left output-full set");
  a_status_read_quiet: assert property (hrd_ev && hs3_r.a2 && !i_core_obuf_wr
      && !i_core_obf_clr |=> obf_r == $past(obf_r))
    else $error("status read changed output-full");
  a_keyboard_irq_out_gating: assert property (##1 o_kb_irq == $past(p2_r[KBC_P2_KEYBOARD_IRQ_OUT]
      && (!flags_r || obf_r)))
    else $error("keyboard irq wrong");
  a_mouse_irq_out_gating: assert property (##1 o_mouse_irq == $past(p2_r[KBC_P2_MOUSE_IRQ_OUT]
      && (!flags_r || !ibf_r)))
    else $error("mouse irq wrong");
  a_ibf_core_clear: assert property (i_core_ibuf_rd && !hwr_ev
      |=> !ibf_r ##1 !o_core_irq_ibf)
    else $error("core read did not clear input-full");
  a_quasi_pulse_len: assert property (qhi_cnt_r <= QC)
    else $error("quasi pin driven high too long");
  a_quasi_rise: assert property ($rose(p1_r[KBC_P1_QA]) && !i_core_od_mode
      |=> q_oe[0] && q_out[0])
    else $error("quasi pin missing high pulse");
  a_od_release: assert property (i_core_od_mode && p1_r[KBC_P1_QA] |=> !q_out[0])
    else $error("open-drain pin driven high");
  a_halt_wake: assert property (!pwr_r[0] && hwr_ev |=> pwr_r[0]
      && (o_core_wake_call != o_core_wake_next))
    else $error("host write did not wake core");
  a_ps2_invert: assert property (##1 ps2_oe_r[KBC_PIN_KB_CLOCK_PIN] == $past(p2_r[KBC_P2_KB_CLOCK_PIN]))
    else $error("keyboard clock drive not inverted port bit");
endmodule // kbc_host_if

// >>> dv/kbc_host_model.sv
// host-side model issuing byte-wide mailbox reads and writes
// assumes the block samples host strobes on i_core_clk
module kbc_host_model
  import kbc_pkg::*;
(
  // clock
  input  wire logic       i_core_clk,
  // host bus
  input  wire logic [7:0] i_rdata,
  output kbc_hbus_t       o_host
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_host = '{rd_n: 1'b1, wr_n: 1'b1, a2: 1'b0, d: 8'hFF};
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // address and data settle three cycles before the strobe
  task automatic wr(input logic a2, input logic [7:0] d);
    o_host.a2 <= a2;
    o_host.d  <= d;
    cyc(3);
    o_host.wr_n <= 1'b0;
    cyc(4);
    o_host.wr_n <= 1'b1;
    cyc(1);
    // released bus no longer shows the byte
    o_host.d <= ~d;
    cyc(3);
  endtask

  task automatic rd(input logic a2, output logic [7:0] q);
    o_host.a2 <= a2;
    cyc(3);
    o_host.rd_n <= 1'b0;
    cyc(5);
    q = i_rdata;
    o_host.rd_n <= 1'b1;
    cyc(4);
  endtask
endmodule // kbc_host_model

// >>> dv/testbench.sv
// self-checking bench for the keyboard mailbox block
// assumes the package, the design and the host model are compiled first
module testbench;
  import kbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, kbi, msi, ga20, tck, tcm, irqi, irqt, run, osc, wc, wn, hoe;
  logic [11:0] pv;
  logic [7:0]  cv, q, hd, st, ib, pin1, ramq, romq;
  logic [3:0]  lv;
  logic [6:0]  ext, po, poe, pin;
  kbc_hbus_t   host;
  int          n_errors, cmp_count, q_hi, n_call, n_next, n_oe;

  // wire levels: driven value where enabled, else the outside level
  assign pin = (poe & po) | (~poe & ext);

  kbc_host_model i_host_model (.i_core_clk(clk), .i_rdata(hd), .o_host(host));

  kbc_host_if i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_host(host), .o_host_data(hd),
    .o_host_data_oe(hoe), .o_kb_irq(kbi), .o_mouse_irq(msi), .o_gate_a20(ga20),
    .i_pin_in(pin), .o_pin_out(po), .o_pin_oe(poe), .i_core_en_flags(pv[4]),
    .i_core_obuf_wr(pv[2]), .i_core_obuf_data(cv), .i_core_obf_clr(pv[10]),
    .i_core_ibuf_rd(pv[3]), .o_core_ibuf_data(ib), .i_core_status_wr(pv[9]),
    .i_core_status_ud(cv), .o_core_status(st), .i_core_p1_wr(pv[0]),
    .i_core_p1_data(cv), .i_core_p2_wr(pv[1]), .i_core_p2_data(cv),
    .i_core_od_mode(lv[3]), .o_core_p1_in(pin1), .o_core_first_test_input(tck),
    .o_core_second_test_input(tcm), .i_core_halt(pv[5]), .i_core_stop(pv[6]),
    .i_core_ibf_ie(lv[0]), .i_core_tmr_ie(lv[1]), .i_core_tmr_en(lv[2]),
    .i_core_tmr_load(pv[8]), .i_core_tmr_data(cv), .i_core_tmr_ack(pv[11]),
    .o_core_irq_ibf(irqi), .o_core_irq_tmr(irqt), .o_core_alu_run(run),
    .o_core_osc_off(osc), .o_core_wake_call(wc), .o_core_wake_next(wn),
    .i_core_ram_we(pv[7]), .i_core_ram_addr(cv), .i_core_ram_wdata(~cv),
    .o_core_ram_rdata(ramq), .i_core_rom_addr(11'h7FF), .o_core_rom_data(romq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (poe[KBC_PIN_Q0] === 1'b1 && po[KBC_PIN_Q0] === 1'b1) q_hi++;
    if (wc === 1'b1) n_call++;
    if (wn === 1'b1) n_next++;
  end

  // read-enable width, sampled mid-cycle
  always @(negedge clk) begin
    if (hoe === 1'b1) n_oe++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle core pulse of kind k with byte v
  task automatic cw(input int k, input logic [7:0] v);
    pv <= 12'h001 << k;
    cv <= v;
    @(posedge clk);
    pv <= '0;
    repeat (4) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    pv = '0;
    cv = '0;
    lv = 4'b0011;
    ext = '1;
    n_errors = 0;
    cmp_count = 0;
    q_hi = 0;
    n_call = 0;
    n_next = 0;
    n_oe = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(st, KBC_ST_RST);
    chk(kbi, 1'b0);
    chk(poe[3:0], 4'hF);
    cw(1, 8'h32);
    chk({kbi, msi, ga20}, 3'b111);
    ext <= 7'h79;
    cw(1, 8'h40);
    chk({kbi, msi, ga20}, 3'b000);
    chk(poe[3:0], 4'h1);
    repeat (6) @(posedge clk);
    chk({tck, tcm, pin1[1:0]}, 4'b0010);
    ext <= '1;
    i_host_model.wr(1'b0, 8'h5A);
    chk(st, 8'h02);
    chk(ib, 8'h5A);
    chk(irqi, 1'b1);
    i_host_model.rd(1'b1, q);
    chk(q, 8'h02);
    chk(st, 8'h02);
    chk(n_oe, 5);
    i_host_model.wr(1'b1, 8'hA5);
    chk(st, 8'h0A);
    chk(ib, 8'hA5);
    cw(3, 8'h00);
    chk({irqi, st}, {1'b0, 8'h08});
    cw(9, 8'hFF);
    chk(st, 8'hFC);
    cw(9, 8'h00);
    cw(2, 8'h3C);
    chk(st[0], 1'b1);
    i_host_model.rd(1'b0, q);
    chk({q, st[0]}, {8'h3C, 1'b1});
    cw(10, 8'h00);
    cw(4, 8'h00);
    cw(1, 8'h30);
    chk({kbi, msi}, 2'b01);
    cw(2, 8'hC3);
    chk({kbi, st[0]}, 2'b11);
    i_host_model.rd(1'b0, q);
    chk({q, kbi, st[0]}, {8'hC3, 2'b00});
    i_host_model.wr(1'b0, 8'h11);
    chk(msi, 1'b0);
    cw(2, 8'h01);
    cw(1, 8'h20);
    chk(kbi, 1'b0);
    cw(0, 8'h7F);
    chk({poe[KBC_PIN_Q0], po[KBC_PIN_Q0]}, 2'b10);
    q_hi = 0;
    cw(0, 8'hFF);
    repeat (12) @(posedge clk);
    chk(q_hi, 10);
    chk(poe[KBC_PIN_Q0], 1'b0);
    lv[3] <= 1'b1;
    cw(0, 8'h7F);
    q_hi = 0;
    cw(0, 8'hFF);
    repeat (12) @(posedge clk);
    chk({q_hi[7:0], poe[KBC_PIN_Q0]}, 9'h000);
    cw(5, 8'h00);
    chk(run, 1'b0);
    i_host_model.wr(1'b0, 8'h22);
    chk({run, n_call[7:0]}, 9'h101);
    lv[0] <= 1'b0;
    cw(6, 8'h00);
    chk(osc, 1'b1);
    i_host_model.wr(1'b0, 8'h33);
    chk({osc, n_next[7:0]}, 9'h001);
    lv[2] <= 1'b1;
    cw(8, 8'hFE);
    chk(irqt, 1'b1);
    lv[2] <= 1'b0;
    cw(11, 8'h00);
    chk(irqt, 1'b0);
    cw(7, 8'h5A);
    chk(ramq, 8'hA5);
    chk(romq, KBC_ROM_FILL);
    end_sim();
  end
endmodule // testbench
